// file: ldc_pkg.sv
// package: register map, field layout and types of the lcd display control block
package ldc_pkg;

	// ----------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------
	localparam logic [15:0] LDC_OFS_DCTL = 16'h50A0;
	localparam logic [15:0] LDC_OFS_CADJ = 16'h50A1;
	localparam logic [15:0] LDC_OFS_IMSK = 16'h50A5;
	localparam logic [15:0] LDC_OFS_IFLG = 16'h50A6;

	// ----------------------------------------
	// field positions
	// ----------------------------------------
	localparam int LDC_BIT_COLREV = 7;
	localparam int LDC_BIT_ROWREV = 6;
	localparam int LDC_BIT_AREA   = 5;
	localparam int LDC_BIT_NEG    = 4;
	localparam int LDC_BIT_FRAME  = 0;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [7:0] LDC_RST_DCTL = 8'hD0;
	localparam logic [3:0] LDC_RST_CADJ = 4'h0;
	localparam logic       LDC_RST_IE   = 1'b0;
	localparam logic       LDC_RST_IF   = 1'b0;

	// ----------------------------------------
	// geometry
	// ----------------------------------------
	localparam int LDC_NCOL = 72;
	localparam int LDC_NROW = 16;

	typedef enum logic [1:0] {
		LDC_DISP_OFF    = 2'b00,
		LDC_DISP_NORMAL = 2'b01,
		LDC_DISP_ALLON  = 2'b10,
		LDC_DISP_ALLOFF = 2'b11
	} ldc_disp_t;

	typedef struct packed {
		logic      col_rev;
		logic      row_rev;
		logic      area_sel;
		logic      neg_n;
		ldc_disp_t disp;
	} ldc_ctrl_t;

	typedef struct packed {
		logic                drive_en;
		logic [3:0]          contrast;
		logic                wave_force;
		logic                wave_static;
		logic                area_sel;
	} ldc_drv_t;

endpackage

// file: ldc_pixmap.sv
// module: maps one frame line of display memory onto column and row pins
`timescale 1ns/10ps
`default_nettype none
module ldc_pixmap
	import ldc_pkg::*;
(
	input  wire logic [LDC_NCOL-1:0] MEM_COL_I,
	input  wire logic [LDC_NROW-1:0] ROW_SEL_I,
	input  wire ldc_pkg::ldc_ctrl_t  CTRL_I,
	output logic      [LDC_NCOL-1:0] COL_O,
	output logic      [LDC_NROW-1:0] ROW_O
);
	genvar gi;

	// ----------------------------------------
	// pixel path
	// ----------------------------------------
	generate
		for (gi = 0; gi < LDC_NCOL; gi++) begin : g_col
			logic pix;
			// ascending when reverse bit is 1
			assign pix = CTRL_I.col_rev ? MEM_COL_I[gi] : MEM_COL_I[LDC_NCOL-1-gi];
			always_comb begin
				case (CTRL_I.disp)
					LDC_DISP_OFF:    COL_O[gi] = 1'b0;
					LDC_DISP_NORMAL: COL_O[gi] = pix ^ ~CTRL_I.neg_n;
					// all-on still honours negative image
					LDC_DISP_ALLON:  COL_O[gi] = ~CTRL_I.neg_n ? 1'b0 : 1'b1;
					LDC_DISP_ALLOFF: COL_O[gi] = 1'b0;
					default:         COL_O[gi] = 1'b0;
				endcase
			end
		end
		for (gi = 0; gi < LDC_NROW; gi++) begin : g_row
			assign ROW_O[gi] = CTRL_I.row_rev ? ROW_SEL_I[gi] : ROW_SEL_I[LDC_NROW-1-gi];
		end
	endgenerate

endmodule
`default_nettype wire

// file: ldc_top.sv
// module: lcd display control registers, pixel mapping and frame interrupt over apb
//
// Design decision made here: the APB register port.
`timescale 1ns/10ps
`default_nettype none
module ldc_top
	import ldc_pkg::*;
(
	input  wire logic                CLK_SYS_I,
	input  wire logic                ARST_N_I,
	input  wire logic                PSEL_I,
	input  wire logic                PENABLE_I,
	input  wire logic                PWRITE_I,
	input  wire logic [15:0]         PADDR_I,
	input  wire logic [31:0]         PWDATA_I,
	input  wire logic [3:0]          PSTRB_I,
	output logic      [31:0]         PRDATA_O,
	output logic                     PREADY_O,
	output logic                     PSLVERR_O,
	input  wire logic                FRAME_I,
	input  wire logic                SLEEP_I,
	input  wire logic [LDC_NCOL-1:0] MEM_COL_I,
	input  wire logic [LDC_NROW-1:0] ROW_SEL_I,
	output logic      [LDC_NCOL-1:0] COL_DRIVE_O,
	output logic      [LDC_NROW-1:0] ROW_DRIVE_O,
	output ldc_pkg::ldc_drv_t        DRV_O,
	output logic                     IRQ_O
);
	import ldc_pkg::*;

	// ----------------------------------------
	// apb decode
	// ----------------------------------------
	logic       wr_en;
	logic       rd_en;
	logic       hit;
	logic       lane0;
	logic [7:0] wbyte;

	assign hit   = (PADDR_I == LDC_OFS_DCTL) || (PADDR_I == LDC_OFS_CADJ) ||
	               (PADDR_I == LDC_OFS_IMSK) || (PADDR_I == LDC_OFS_IFLG);
	// registers sit on byte addresses; the byte is taken from lane 0
	assign lane0 = PSTRB_I[0];
	assign wbyte = PWDATA_I[7:0];
	assign wr_en = PSEL_I && PENABLE_I && PWRITE_I && hit && lane0;
	assign rd_en = PSEL_I && !PENABLE_I && !PWRITE_I;
	// zero wait states: every access completes in its first access cycle
	assign PREADY_O  = 1'b1;
	assign PSLVERR_O = PSEL_I && PENABLE_I && !hit;

	// ----------------------------------------
	// control registers
	// ----------------------------------------
	ldc_ctrl_t  ctrl_q;
	logic [3:0] contrast_q;
	logic       frame_ie_q;
	logic       frame_if_q;

	// sleep input deliberately unused: state survives sleep entry
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			ctrl_q.col_rev  <= LDC_RST_DCTL[LDC_BIT_COLREV];
			ctrl_q.row_rev  <= LDC_RST_DCTL[LDC_BIT_ROWREV];
			ctrl_q.area_sel <= LDC_RST_DCTL[LDC_BIT_AREA];
			ctrl_q.neg_n    <= LDC_RST_DCTL[LDC_BIT_NEG];
			ctrl_q.disp     <= ldc_disp_t'(LDC_RST_DCTL[1:0]);
		end else if (wr_en && PADDR_I == LDC_OFS_DCTL) begin
			ctrl_q.col_rev  <= wbyte[LDC_BIT_COLREV];
			ctrl_q.row_rev  <= wbyte[LDC_BIT_ROWREV];
			ctrl_q.area_sel <= wbyte[LDC_BIT_AREA];
			ctrl_q.neg_n    <= wbyte[LDC_BIT_NEG];
			ctrl_q.disp     <= ldc_disp_t'(wbyte[1:0]);
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			contrast_q <= LDC_RST_CADJ;
		end else if (wr_en && PADDR_I == LDC_OFS_CADJ) begin
			contrast_q <= wbyte[3:0];
		end
	end

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			frame_ie_q <= LDC_RST_IE;
		end else if (wr_en && PADDR_I == LDC_OFS_IMSK) begin
			frame_ie_q <= wbyte[LDC_BIT_FRAME];
		end
	end

	// ----------------------------------------
	// frame flag
	// ----------------------------------------
	logic frame_d1_q;
	logic frame_rise;
	logic flag_clr;

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			frame_d1_q <= 1'b0;
		end else begin
			frame_d1_q <= FRAME_I;
		end
	end

	assign frame_rise = FRAME_I && !frame_d1_q;
	assign flag_clr   = wr_en && PADDR_I == LDC_OFS_IFLG && wbyte[LDC_BIT_FRAME];

	// set beats a clear landing in the same cycle
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			frame_if_q <= LDC_RST_IF;
		end else if (frame_rise) begin
			frame_if_q <= 1'b1;
		end else if (flag_clr) begin
			frame_if_q <= 1'b0;
		end
	end

	// level request, follows flag and enable
	assign IRQ_O = frame_if_q && frame_ie_q;

	// ----------------------------------------
	// read data
	// ----------------------------------------
	logic [7:0] rbyte;

	always_comb begin
		rbyte = 8'h00;
		case (PADDR_I)
			LDC_OFS_DCTL: rbyte = {ctrl_q.col_rev, ctrl_q.row_rev, ctrl_q.area_sel, ctrl_q.neg_n,
			                       2'b00, ctrl_q.disp};
			LDC_OFS_CADJ: rbyte = {4'h0, contrast_q};
			LDC_OFS_IMSK: rbyte = {7'h00, frame_ie_q};
			LDC_OFS_IFLG: rbyte = {7'h00, frame_if_q};
			default:      rbyte = 8'h00;
		endcase
	end

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			PRDATA_O <= 32'h0000_0000;
		end else if (rd_en) begin
			PRDATA_O <= {24'h00_0000, rbyte};
		end
	end

	// ----------------------------------------
	// drive controls
	// ----------------------------------------
	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			DRV_O <= '0;
		end else begin
			// off: regulator disabled, wave controls low; contrast and area select still follow their registers
			DRV_O.drive_en    <= ctrl_q.disp != LDC_DISP_OFF;
			DRV_O.contrast    <= contrast_q;
			DRV_O.wave_force  <= ctrl_q.disp == LDC_DISP_ALLON || ctrl_q.disp == LDC_DISP_ALLOFF;
			DRV_O.wave_static <= ctrl_q.disp == LDC_DISP_ALLOFF;
			DRV_O.area_sel    <= ctrl_q.area_sel;
		end
	end

	// ----------------------------------------
	// pin mapping
	// ----------------------------------------
	logic [LDC_NCOL-1:0] col_d;
	logic [LDC_NROW-1:0] row_d;

	ldc_pixmap u_pixmap (
		.MEM_COL_I (MEM_COL_I),
		.ROW_SEL_I (ROW_SEL_I),
		.CTRL_I    (ctrl_q),
		.COL_O     (col_d),
		.ROW_O     (row_d)
	);

	always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
		if (!ARST_N_I) begin
			COL_DRIVE_O <= '0;
			ROW_DRIVE_O <= '0;
		end else begin
			COL_DRIVE_O <= col_d;
			ROW_DRIVE_O <= row_d;
		end
	end

	// ----------------------------------------
	// assertions
	// ----------------------------------------
	sequence s_clear_write;
		wr_en && PADDR_I == LDC_OFS_IFLG && PWDATA_I[0];
	endsequence

	property p_flag_set;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) FRAME_I && !frame_d1_q |=> frame_if_q;
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("frame edge did not set flag");

	property p_flag_clr;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) s_clear_write ##0 !frame_rise |=> !frame_if_q;
	endproperty
	a_flag_clr: assert property (p_flag_clr) else $error("write one did not clear flag");

	property p_flag_keep;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) frame_if_q && !flag_clr |=> frame_if_q;
	endproperty
	a_flag_keep: assert property (p_flag_keep) else $error("flag dropped without clear");

	property p_irq_level;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) $rose(IRQ_O)
			|-> $past(frame_rise) || $past(wr_en && PADDR_I == LDC_OFS_IMSK);
	endproperty
	a_irq_level: assert property (p_irq_level) else $error("request rose without cause");

	property p_irq_edge;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) frame_ie_q && !frame_if_q && frame_rise
			##1 frame_ie_q |-> IRQ_O;
	endproperty
	a_irq_edge: assert property (p_irq_edge) else $error("request missed frame edge");

	property p_irq_drop;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) IRQ_O && flag_clr && !frame_rise |=> !IRQ_O;
	endproperty
	a_irq_drop: assert property (p_irq_drop) else $error("request held after clear");

	property p_off_drive;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) ctrl_q.disp == LDC_DISP_OFF ##1
			ctrl_q.disp == LDC_DISP_OFF |-> !DRV_O.drive_en;
	endproperty
	a_off_drive: assert property (p_off_drive) else $error("drive enabled while off");

	property p_allon_neg;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) ctrl_q.disp == LDC_DISP_ALLON && !ctrl_q.neg_n
			|=> COL_DRIVE_O == '0;
	endproperty
	a_allon_neg: assert property (p_allon_neg) else $error("all on not inverted");

	property p_allon_pos;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) ctrl_q.disp == LDC_DISP_ALLON && ctrl_q.neg_n
			|=> COL_DRIVE_O == '1;
	endproperty
	a_allon_pos: assert property (p_allon_pos) else $error("all on columns not set");

	property p_contrast;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) wr_en && PADDR_I == LDC_OFS_CADJ
			|=> ##1 DRV_O.contrast == $past(PWDATA_I[3:0], 2);
	endproperty
	a_contrast: assert property (p_contrast) else $error("contrast not applied");

	property p_sleep_hold;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) SLEEP_I && !(wr_en && PADDR_I == LDC_OFS_DCTL)
			|=> $stable(ctrl_q.disp);
	endproperty
	a_sleep_hold: assert property (p_sleep_hold) else $error("sleep changed display state");

	sequence s_ctrl_write;
		wr_en && PADDR_I == LDC_OFS_DCTL;
	endsequence

	sequence s_mask_write;
		wr_en && PADDR_I == LDC_OFS_IMSK;
	endsequence

	property p_ctrl_write;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) s_ctrl_write
			|=> ctrl_q.disp == $past(PWDATA_I[1:0]) && ctrl_q.neg_n == $past(PWDATA_I[LDC_BIT_NEG]);
	endproperty
	a_ctrl_write: assert property (p_ctrl_write) else $error("display control write not taken");

	property p_area_sel;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) s_ctrl_write
			|=> ##1 DRV_O.area_sel == $past(PWDATA_I[LDC_BIT_AREA], 2);
	endproperty
	a_area_sel: assert property (p_area_sel) else $error("area select not exported");

	property p_mask_write;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) s_mask_write
			|=> frame_ie_q == $past(PWDATA_I[LDC_BIT_FRAME]);
	endproperty
	a_mask_write: assert property (p_mask_write) else $error("enable write not taken");

	property p_flag_quiet;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) !frame_if_q && !frame_rise |=> !frame_if_q;
	endproperty
	a_flag_quiet: assert property (p_flag_quiet) else $error("flag set without frame edge");

	property p_wave_allon;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) ctrl_q.disp == LDC_DISP_ALLON
			|=> DRV_O.wave_force && !DRV_O.wave_static && DRV_O.drive_en;
	endproperty
	a_wave_allon: assert property (p_wave_allon) else $error("all on waveform not dynamic");

	property p_wave_alloff;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) ctrl_q.disp == LDC_DISP_ALLOFF
			|=> DRV_O.wave_force && DRV_O.wave_static;
	endproperty
	a_wave_alloff: assert property (p_wave_alloff) else $error("all off waveform not static");

	property p_alloff_cols;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) ctrl_q.disp == LDC_DISP_ALLOFF
			|=> COL_DRIVE_O == '0;
	endproperty
	a_alloff_cols: assert property (p_alloff_cols) else $error("all off columns driven");

	property p_off_cols;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) ctrl_q.disp == LDC_DISP_OFF |=> COL_DRIVE_O == '0;
	endproperty
	a_off_cols: assert property (p_off_cols) else $error("columns driven while off");

	property p_normal_pos;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) ctrl_q.disp == LDC_DISP_NORMAL && ctrl_q.neg_n
			&& ctrl_q.col_rev |=> COL_DRIVE_O == $past(MEM_COL_I);
	endproperty
	a_normal_pos: assert property (p_normal_pos) else $error("normal columns not memory");

	property p_normal_neg;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) ctrl_q.disp == LDC_DISP_NORMAL && !ctrl_q.neg_n
			&& ctrl_q.col_rev |=> COL_DRIVE_O == ~$past(MEM_COL_I);
	endproperty
	a_normal_neg: assert property (p_normal_neg) else $error("negative columns not inverted");

	property p_col_desc;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) ctrl_q.disp == LDC_DISP_NORMAL && ctrl_q.neg_n
			&& !ctrl_q.col_rev |=> COL_DRIVE_O[0] == $past(MEM_COL_I[LDC_NCOL-1])
			&& COL_DRIVE_O[LDC_NCOL-1] == $past(MEM_COL_I[0]);
	endproperty
	a_col_desc: assert property (p_col_desc) else $error("column order not descending");

	property p_row_asc;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) ctrl_q.row_rev |=> ROW_DRIVE_O == $past(ROW_SEL_I);
	endproperty
	a_row_asc: assert property (p_row_asc) else $error("row order not ascending");

	property p_row_desc;
		@(posedge CLK_SYS_I) disable iff (!ARST_N_I) !ctrl_q.row_rev
			|=> ROW_DRIVE_O[0] == $past(ROW_SEL_I[LDC_NROW-1])
			&& ROW_DRIVE_O[LDC_NROW-1] == $past(ROW_SEL_I[0]);
	endproperty
	a_row_desc: assert property (p_row_desc) else $error("row order not descending");

endmodule
`default_nettype wire

// file: ldc_panel_model.sv
// lcd panel model seen from the column and row drive pins
`timescale 1ns/10ps
`default_nettype none
module ldc_panel_model
	import ldc_pkg::*;
(
	input  wire logic [LDC_NCOL-1:0] col_i,
	input  wire logic [LDC_NROW-1:0] row_i,
	input  wire ldc_pkg::ldc_drv_t   drv_i,
	output logic      [LDC_NCOL-1:0] lit_o
);
	// unbiased glass stays blank whatever the pins carry
	assign lit_o = (drv_i.drive_en && (|row_i)) ? col_i : '0;
endmodule
`default_nettype wire

// file: test_lcd_display_control_irq.sv
// testbench of the lcd display control and frame interrupt block
`timescale 1ns/10ps
`default_nettype none
module test_lcd_display_control_irq;
	import ldc_pkg::*;
	localparam logic [71:0] MEM  = 72'h81_2345_6789_ABCD_EF01;
	localparam logic [15:0] RSEL = 16'h0003;
	logic              clk_sys;
	logic              arst_n;
	logic              psel;
	logic              penable;
	logic              pwrite;
	logic [15:0]       paddr;
	logic [31:0]       pwdata;
	logic [3:0]        pstrb;
	logic [31:0]       prdata;
	logic              pready;
	logic              slverr;
	logic              frame;
	logic              sleep;
	logic [71:0]       mem;
	logic [15:0]       rsel;
	logic [71:0]       col;
	logic [15:0]       row;
	ldc_drv_t          drv;
	logic              irq;
	logic [71:0]       lit;
	logic [31:0]       rd;
	logic              serr;
	int                err_total = 0;
	int                cmp_count = 0;

	ldc_top u_dut (.CLK_SYS_I(clk_sys), .ARST_N_I(arst_n), .PSEL_I(psel), .PENABLE_I(penable),
		.PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata),
		.PREADY_O(pready), .PSLVERR_O(slverr), .FRAME_I(frame), .SLEEP_I(sleep), .MEM_COL_I(mem),
		.ROW_SEL_I(rsel), .COL_DRIVE_O(col), .ROW_DRIVE_O(row), .DRV_O(drv), .IRQ_O(irq));
	ldc_panel_model u_panel (.col_i(col), .row_i(row), .drv_i(drv), .lit_o(lit));

	initial begin
		clk_sys = 1'b0;
		forever #5 clk_sys = ~clk_sys;
	end

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic chk(input string nm, input logic [71:0] e, input logic [71:0] s);
		cmp_count++;
		if (s !== e) begin
			$display("[ERR] %s expected %h seen %h", nm, e, s);
			err_total++;
		end
	endtask

	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	// one idle edge first so a released strobe is never raised in the same step
	task automatic apb(input logic w, input logic [15:0] a, input logic [7:0] d);
		int n;
		n = 0;
		@(posedge clk_sys);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h00_0000, d};
		@(posedge clk_sys);
		penable <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
		end while (pready !== 1'b1 && n < 100);
		if (pready !== 1'b1) begin
			$display("[ERR] pready expected 1 seen %b", pready);
			err_total++;
		end
		rd = prdata;
		serr = slverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic pulse;
		@(posedge clk_sys);
		frame <= 1'b1;
		#1;
		chk("irq_before_edge", 1'b0, irq);
		@(posedge clk_sys);
		frame <= 1'b0;
		#1;
	endtask

	task report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	// ----------------------------------------
	// scenarios
	// ----------------------------------------
	task t_reset;
		apb(1'b0, LDC_OFS_DCTL, 8'h00);
		chk("dctl", 8'hD0, rd);
		apb(1'b0, LDC_OFS_CADJ, 8'h00);
		chk("cadj", 8'h00, rd);
		apb(1'b0, LDC_OFS_IMSK, 8'h00);
		chk("imsk", 8'h00, rd);
		chk("drive_en", 1'b0, drv.drive_en);
		apb(1'b0, 16'h50A2, 8'h00);
		chk("slverr", 1'b1, serr);
		chk("unmapped", 32'h0000_0000, rd);
		$display("test reset done");
	endtask

	task t_modes;
		logic [7:0]  v;
		logic [71:0] e;
		for (int s = 0; s < 4; s++) begin
			for (int n = 0; n < 2; n++) begin
				v = {3'b110, n[0], 2'b00, s[1:0]};
				apb(1'b1, LDC_OFS_DCTL, v);
				tick(2);
				e = (s == 1) ? (MEM ^ {72{~n[0]}}) : (s == 2) ? {72{n[0]}} : '0;
				chk("col", e, col);
				chk("drive_en", s != 0, drv.drive_en);
				chk("wave_force", s >= 2, drv.wave_force);
				chk("wave_static", s == 3, drv.wave_static);
				chk("lit", e, lit);
				apb(1'b0, LDC_OFS_DCTL, 8'h00);
				chk("dctl", v, rd);
			end
		end
		$display("test modes done");
	endtask

	task t_order;
		logic [71:0] ec;
		logic [15:0] er;
		ec = {<<{MEM}};
		er = {<<{RSEL}};
		apb(1'b1, LDC_OFS_DCTL, 8'h31);
		tick(2);
		chk("col_rev", ec, col);
		chk("row_rev", er, row);
		chk("area", 1'b1, drv.area_sel);
		apb(1'b1, LDC_OFS_DCTL, 8'hD1);
		tick(2);
		chk("col_fwd", MEM, col);
		chk("row_fwd", RSEL, row);
		chk("area", 1'b0, drv.area_sel);
		apb(1'b1, LDC_OFS_CADJ, 8'hFF);
		tick(2);
		chk("contrast", 4'hF, drv.contrast);
		apb(1'b0, LDC_OFS_CADJ, 8'h00);
		chk("cadj", 8'h0F, rd);
		pstrb <= 4'h0;
		apb(1'b1, LDC_OFS_CADJ, 8'h03);
		pstrb <= 4'hF;
		apb(1'b0, LDC_OFS_CADJ, 8'h00);
		chk("cadj_nostrb", 8'h0F, rd);
		$display("test order and contrast done");
	endtask

	task t_sleep;
		apb(1'b1, LDC_OFS_DCTL, 8'hD3);
		@(posedge clk_sys);
		sleep <= 1'b1;
		apb(1'b0, LDC_OFS_DCTL, 8'h00);
		chk("dctl_sleep", 8'hD3, rd);
		sleep <= 1'b0;
		apb(1'b1, LDC_OFS_DCTL, 8'hD0);
		sleep <= 1'b1;
		apb(1'b0, LDC_OFS_DCTL, 8'h00);
		chk("dctl_sleep_off", 8'hD0, rd);
		sleep <= 1'b0;
		$display("test sleep done");
	endtask

	task t_rereset;
		@(posedge clk_sys);
		arst_n <= 1'b0;
		tick(2);
		chk("contrast_in_reset", 4'h0, drv.contrast);
		@(posedge clk_sys);
		arst_n <= 1'b1;
		apb(1'b0, LDC_OFS_DCTL, 8'h00);
		chk("dctl_rst", 8'hD0, rd);
		apb(1'b0, LDC_OFS_CADJ, 8'h00);
		chk("cadj_rst", 8'h00, rd);
		$display("test mid-run reset done");
	endtask

	task t_irq;
		pulse;
		chk("irq_masked", 1'b0, irq);
		apb(1'b0, LDC_OFS_IFLG, 8'h00);
		chk("flag", 8'h01, rd);
		apb(1'b1, LDC_OFS_IFLG, 8'h00);
		apb(1'b0, LDC_OFS_IFLG, 8'h00);
		chk("flag_w0", 8'h01, rd);
		apb(1'b1, LDC_OFS_IFLG, 8'h01);
		apb(1'b0, LDC_OFS_IFLG, 8'h00);
		chk("flag_w1", 8'h00, rd);
		apb(1'b1, LDC_OFS_IMSK, 8'h01);
		tick(1);
		chk("irq_clean", 1'b0, irq);
		pulse;
		chk("irq_edge", 1'b1, irq);
		tick(5);
		chk("irq_level", 1'b1, irq);
		apb(1'b1, LDC_OFS_IFLG, 8'h01);
		#1;
		chk("irq_drop", 1'b0, irq);
		$display("test irq done");
	endtask

	initial begin
		arst_n = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 16'h0000;
		pwdata = 32'h0000_0000;
		pstrb = 4'hF;
		frame = 1'b0;
		sleep = 1'b0;
		mem = MEM;
		rsel = RSEL;
		repeat (4) @(posedge clk_sys);
		arst_n <= 1'b1;
		t_reset;
		t_modes;
		t_order;
		t_rereset;
		t_sleep;
		t_irq;
		report_and_stop;
	end

	initial begin
		repeat (20000) @(posedge clk_sys);
		err_total++;
		report_and_stop;
	end
endmodule
`default_nettype wire
